/* rtl/usr_pkg.sv */
// constants and types of the synchronous slave receiver
package usr_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_INT_CTRL = 8'h0b;
  localparam logic [7:0] IDX_PFLAGS = 8'h0c;
  localparam logic [7:0] IDX_RX_STAT = 8'h18;
  localparam logic [7:0] IDX_RX_BUF = 8'h1a;
  localparam logic [7:0] IDX_PENABLES = 8'h8c;
  localparam logic [7:0] IDX_TX_STAT = 8'h98;
  localparam logic [7:0] IDX_BAUD = 8'h99;
  localparam logic [7:0] IDX_EVT_STAT = 8'ha0;
  localparam logic [7:0] IDX_EVT_MASK = 8'ha1;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_TX_STAT = 8'h02;
  // bit positions
  localparam int unsigned B_GIE = 7;
  localparam int unsigned B_PERIPHERAL_INTERRUPT_ENABLE = 6;
  localparam int unsigned B_RECEIVE_INTERRUPT_FLAG = 5;
  localparam int unsigned B_RECEIVE_INTERRUPT_ENABLE = 5;
  localparam int unsigned B_SERIAL_PORT_ENABLE = 7;
  localparam int unsigned B_RX9 = 6;
  localparam int unsigned B_SINGLE_RECEIVE_ENABLE = 5;
  localparam int unsigned B_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int unsigned B_FRAMING_ERROR_FLAG = 2;
  localparam int unsigned B_OVERRUN_ERROR_FLAG = 1;
  localparam int unsigned B_RECEIVED_NINTH_BIT = 0;
  localparam int unsigned B_CLOCK_SOURCE_SELECT = 7;
  localparam int unsigned B_SYNC = 4;
  localparam int unsigned B_TRMT = 1;
  localparam int unsigned EV_WORD = 0;
  localparam int unsigned EV_OVR = 1;
  localparam int unsigned EV_N = 2;
  // word lengths and interrupt vector
  localparam logic [3:0] LEN_8 = 4'h8;
  localparam logic [3:0] LEN_9 = 4'h9;
  localparam logic [12:0] VECTOR_ADDR = 13'h0004;
  typedef enum logic [0:0] {
    ST_OFF = 1'b0,
    ST_SHIFT = 1'b1
  } usr_rx_state_t;
endpackage

/* rtl/usr_word_if.sv */
// word hand-over between receive controller and shifter
`timescale 1ns/1ns
interface usr_word_if;
  logic en;
  logic nine;
  logic valid;
  logic [8:0] data;
  modport ctl (output en, output nine, input valid, input data);
  modport shf (input en, input nine, output valid, output data);
endinterface

/* rtl/usr_shifter.sv */
// shift clock synchroniser and receive shift register
`timescale 1ns/1ns
module usr_shifter
  import usr_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // link pins
  input wire logic sck_pin,
  input wire logic sdata_pin,
  // word hand-over
  usr_word_if.shf w
);
  logic ck_s1_ff, ck_s2_ff, ck_s3_ff, dt_s1_ff, dt_s2_ff;
  logic [8:0] shift_ff, nxt_shift;
  logic [3:0] cnt_ff;
  logic valid_ff;
  logic [8:0] data_ff;
  usr_rx_state_t state_ff;
  logic fall;
  logic [3:0] len;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ck_s1_ff <= 1'b0;
      ck_s2_ff <= 1'b0;
      ck_s3_ff <= 1'b0;
      dt_s1_ff <= 1'b0;
      dt_s2_ff <= 1'b0;
    end else begin
      ck_s1_ff <= sck_pin;
      ck_s2_ff <= ck_s1_ff;
      ck_s3_ff <= ck_s2_ff;
      dt_s1_ff <= sdata_pin;
      dt_s2_ff <= dt_s1_ff;
    end
  end

  // data is taken on the falling shift clock edge, lsb first
  assign fall = ck_s3_ff & ~ck_s2_ff;
  assign len = w.nine ? LEN_9 : LEN_8;
  assign nxt_shift = {dt_s2_ff, shift_ff[8:1]};

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_ff <= ST_OFF;
      cnt_ff <= 4'h0;
      shift_ff <= 9'h000;
      valid_ff <= 1'b0;
      data_ff <= 9'h000;
    end else begin
      valid_ff <= 1'b0;
      case (state_ff)
        ST_OFF: begin
          cnt_ff <= 4'h0;
          if (w.en) begin
            state_ff <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (!w.en) begin
            state_ff <= ST_OFF;
            cnt_ff <= 4'h0;
          end else if (fall) begin
            shift_ff <= nxt_shift;
            if (cnt_ff + 4'h1 == len) begin
              cnt_ff <= 4'h0;
              valid_ff <= 1'b1;
              data_ff <= w.nine ? nxt_shift : {1'b0, nxt_shift[8:1]};
            end else begin
              cnt_ff <= cnt_ff + 4'h1;
            end
          end
        end
        default: state_ff <= ST_OFF;
      endcase
    end
  end

  assign w.valid = valid_ff;
  assign w.data = data_ff;

  AST_NO_WORD_WHEN_OFF: assert property (@(posedge clk_sys) disable iff (reset)
    (state_ff == ST_OFF) |=> !valid_ff)
    else $error("word produced while receiver off");
endmodule

/* rtl/usr_rx.sv */
// synchronous slave receiver with apb register file
// Function
// - slave reception works as master reception
// - single receive enable has no effect
// - reception continues while the core sleeps
// - full word moves into receive buffer
// - enabled receive interrupt wakes sleeping core
// - wake with global enable branches to vector
// - nine bit enable selects nine bit words
// - reception starts only with continuous enable
// - word sets flag, interrupt only when enabled
// - status shows ninth bit and error flags
// - low eight bits read from receive buffer
// - clearing continuous enable clears overrun error
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
module usr_rx
  import usr_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link pins
  input wire logic sck_pin,
  input wire logic sdata_pin,
  // core side
  input wire logic core_sleep,
  output logic wake,
  output logic core_irq,
  output logic [12:0] branch_vector,
  output logic irq
);
  usr_word_if w ();

  usr_shifter u_shf (
    .clk_sys(clk_sys),
    .reset(reset),
    .sck_pin(sck_pin),
    .sdata_pin(sdata_pin),
    .w(w)
  );

  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff, rd_valid_ff;
  logic [7:0] int_ctrl_ff, pflags_ff, pen_ff, tx_stat_ff, baud_ff, rx_buf_ff;
  logic [4:0] rx_ctl_ff;
  logic overrun_error_flag_ff, received_ninth_bit_ff, receive_interrupt_flag_ff;
  logic [EV_N-1:0] evt_stat_ff, evt_mask_ff, nxt_evt_stat, evt_set;
  logic wake_ff, core_irq_ff, irq_ff;
  logic [12:0] branch_vector_ff;
  logic [7:0] idx, rd_val;
  logic setup, done, wr, rd, addr_ok;
  logic serial_port_enable, rx9, continuous_receive_enable, single_receive_enable, clock_source_select, sync_mode, receive_interrupt_enable, global_interrupt_enable, peripheral_interrupt_enable;
  logic rx_en, word_in, load, ovr, rd_buf, rd_clr;

  // true for every index that the register file answers
  function automatic logic is_mapped(input logic [7:0] i);
    case (i)
      IDX_INT_CTRL, IDX_PFLAGS, IDX_RX_STAT, IDX_RX_BUF, IDX_PENABLES,
      IDX_TX_STAT, IDX_BAUD, IDX_EVT_STAT, IDX_EVT_MASK: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // true for a completed write to index i
  function automatic logic wr_hit(input logic [7:0] i, input logic w_en,
                                  input logic [7:0] cur, input logic ok);
    wr_hit = w_en & ok & (cur == i);
  endfunction

  // apb decode
  assign idx = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0) && is_mapped(idx);
  assign setup = psel & ~penable;
  assign done = psel & penable & pready_ff;
  assign wr = done & pwrite;
  assign rd = done & ~pwrite;

  // control fields
  assign serial_port_enable = rx_ctl_ff[B_SERIAL_PORT_ENABLE-3];
  assign rx9 = rx_ctl_ff[B_RX9-3];
  assign single_receive_enable = rx_ctl_ff[B_SINGLE_RECEIVE_ENABLE-3];
  assign continuous_receive_enable = rx_ctl_ff[B_CONTINUOUS_RECEIVE_ENABLE-3];
  assign clock_source_select = tx_stat_ff[B_CLOCK_SOURCE_SELECT];
  assign sync_mode = tx_stat_ff[B_SYNC];
  assign receive_interrupt_enable = pen_ff[B_RECEIVE_INTERRUPT_ENABLE];
  assign global_interrupt_enable = int_ctrl_ff[B_GIE];
  assign peripheral_interrupt_enable = int_ctrl_ff[B_PERIPHERAL_INTERRUPT_ENABLE];

  // receiver runs in sync slave mode with continuous enable, no sleep gating
  assign rx_en = serial_port_enable & sync_mode & ~clock_source_select & continuous_receive_enable & ~overrun_error_flag_ff;
  assign w.en = rx_en;
  assign w.nine = rx9;
  assign word_in = w.valid & rx_en;
  assign rd_buf = rd & addr_ok & (idx == IDX_RX_BUF);
  assign rd_clr = rd_buf & rd_valid_ff;
  assign load = word_in & (~receive_interrupt_flag_ff | rd_clr);
  assign ovr = word_in & ~load;

  // register read view
  always_comb begin
    rd_val = RST_ZERO;
    case (idx)
      IDX_INT_CTRL: rd_val = int_ctrl_ff;
      IDX_PFLAGS: rd_val = pflags_ff | ({7'h00, receive_interrupt_flag_ff} << B_RECEIVE_INTERRUPT_FLAG);
      IDX_RX_STAT: rd_val = {rx_ctl_ff, 1'b0, overrun_error_flag_ff, received_ninth_bit_ff};
      IDX_RX_BUF: rd_val = rx_buf_ff;
      IDX_PENABLES: rd_val = pen_ff;
      IDX_TX_STAT: rd_val = tx_stat_ff;
      IDX_BAUD: rd_val = baud_ff;
      IDX_EVT_STAT: rd_val = {6'h00, evt_stat_ff};
      IDX_EVT_MASK: rd_val = {6'h00, evt_mask_ff};
      default: rd_val = RST_ZERO;
    endcase
  end

  // apb answer, one cycle after setup
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      rd_valid_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~addr_ok;
      prdata_ff <= (setup & ~pwrite & addr_ok) ? {24'h000000, rd_val} : 32'h0000_0000;
      rd_valid_ff <= setup & receive_interrupt_flag_ff;
    end
  end

  // software registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      int_ctrl_ff <= RST_ZERO;
      pflags_ff <= RST_ZERO;
      pen_ff <= RST_ZERO;
      tx_stat_ff <= RST_TX_STAT;
      baud_ff <= RST_ZERO;
      rx_ctl_ff <= 5'h00;
      evt_mask_ff <= '0;
    end else begin
      if (wr_hit(IDX_INT_CTRL, wr, idx, addr_ok)) int_ctrl_ff <= pwdata[7:0];
      if (wr_hit(IDX_PFLAGS, wr, idx, addr_ok)) begin
        pflags_ff <= pwdata[7:0] & ~(8'h01 << B_RECEIVE_INTERRUPT_FLAG);
      end
      if (wr_hit(IDX_PENABLES, wr, idx, addr_ok)) pen_ff <= pwdata[7:0];
      if (wr_hit(IDX_TX_STAT, wr, idx, addr_ok)) begin
        tx_stat_ff <= pwdata[7:0] | (8'h01 << B_TRMT);
      end
      if (wr_hit(IDX_BAUD, wr, idx, addr_ok)) baud_ff <= pwdata[7:0];
      if (wr_hit(IDX_RX_STAT, wr, idx, addr_ok)) rx_ctl_ff <= pwdata[7:3];
      if (wr_hit(IDX_EVT_MASK, wr, idx, addr_ok)) evt_mask_ff <= pwdata[EV_N-1:0];
    end
  end

  // receive buffer, ninth bit and receive flag
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_buf_ff <= RST_ZERO;
      received_ninth_bit_ff <= 1'b0;
      receive_interrupt_flag_ff <= 1'b0;
    end else begin
      if (load) begin
        rx_buf_ff <= w.data[7:0];
        received_ninth_bit_ff <= rx9 & w.data[8];
        receive_interrupt_flag_ff <= 1'b1;
      end else if (rd_clr) begin
        receive_interrupt_flag_ff <= 1'b0;
      end
    end
  end

  // overrun error, held until continuous enable is cleared
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      overrun_error_flag_ff <= 1'b0;
    end else if (!continuous_receive_enable) begin
      overrun_error_flag_ff <= 1'b0;
    end else if (ovr) begin
      overrun_error_flag_ff <= 1'b1;
    end
  end

  // event status, write one to clear, set wins
  assign evt_set = {ovr, load};
  always_comb begin
    nxt_evt_stat = evt_stat_ff;
    if (wr_hit(IDX_EVT_STAT, wr, idx, addr_ok)) begin
      nxt_evt_stat = evt_stat_ff & ~pwdata[EV_N-1:0];
    end
    nxt_evt_stat = nxt_evt_stat | evt_set;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      evt_stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      evt_stat_ff <= nxt_evt_stat;
      irq_ff <= |(evt_stat_ff & evt_mask_ff);
    end
  end

  // core interrupt, wake and vector
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wake_ff <= 1'b0;
      core_irq_ff <= 1'b0;
      branch_vector_ff <= 13'h0000;
    end else begin
      wake_ff <= core_sleep & receive_interrupt_flag_ff & receive_interrupt_enable;
      core_irq_ff <= receive_interrupt_flag_ff & receive_interrupt_enable & peripheral_interrupt_enable & global_interrupt_enable;
      branch_vector_ff <= (receive_interrupt_flag_ff & receive_interrupt_enable & peripheral_interrupt_enable & global_interrupt_enable) ? VECTOR_ADDR : 13'h0000;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign wake = wake_ff;
  assign core_irq = core_irq_ff;
  assign branch_vector = branch_vector_ff;
  assign irq = irq_ff;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  AST_LOAD_BUFFER: assert property (
    load |=> (rx_buf_ff == $past(w.data[7:0])) && receive_interrupt_flag_ff)
    else $error("completed word not in receive buffer");

  AST_FLAG_ON_WORD: assert property (
    (word_in && !receive_interrupt_flag_ff) |=> receive_interrupt_flag_ff ##1 (core_irq_ff == (receive_interrupt_enable && peripheral_interrupt_enable && global_interrupt_enable)))
    else $error("receive flag or interrupt request wrong after word");

  AST_OVERRUN: assert property (
    (word_in && receive_interrupt_flag_ff && !rd_clr) |=> overrun_error_flag_ff && !rx_en && $stable(rx_buf_ff))
    else $error("overrun not flagged or buffer overwritten");

  AST_CONTINUOUS_RECEIVE_ENABLE_CLEARS: assert property (
    (!continuous_receive_enable && overrun_error_flag_ff) |=> !overrun_error_flag_ff)
    else $error("overrun kept after continuous enable cleared");

  AST_NINTH_BIT: assert property (
    (load && !rx9) |=> !received_ninth_bit_ff)
    else $error("ninth bit set in eight bit mode");

  AST_READ_CLEARS: assert property (
    (rd_clr && !word_in) |=> !receive_interrupt_flag_ff)
    else $error("buffer read left receive flag set");

  AST_WAKE: assert property (
    (core_sleep && receive_interrupt_flag_ff && receive_interrupt_enable) |=> wake_ff)
    else $error("no wake on enabled receive interrupt in sleep");

  AST_VECTOR: assert property (
    (receive_interrupt_flag_ff && receive_interrupt_enable && peripheral_interrupt_enable && global_interrupt_enable) |=> branch_vector_ff == VECTOR_ADDR)
    else $error("vector not presented with interrupt");

  AST_NO_RX_WITHOUT_CONTINUOUS_RECEIVE_ENABLE: assert property (
    !continuous_receive_enable |=> !receive_interrupt_flag_ff || $past(receive_interrupt_flag_ff))
    else $error("word accepted without continuous enable");

  AST_SINGLE_RECEIVE_ENABLE_IGNORED: assert property (
    (continuous_receive_enable && serial_port_enable && sync_mode && !clock_source_select && !overrun_error_flag_ff) |-> w.en)
    else $error("single receive enable gates reception");

  AST_APB_ONE_WAIT: assert property (
    setup |=> pready_ff ##1 !pready_ff || setup)
    else $error("apb answer timing wrong");

  AST_NO_IRQ_WITHOUT_RECEIVE_INTERRUPT_ENABLE: assert property (
    !receive_interrupt_enable |=> !core_irq_ff)
    else $error("core interrupt raised with receive interrupt disabled");

  AST_VECTOR_IDLE: assert property (
    !(receive_interrupt_flag_ff && receive_interrupt_enable && peripheral_interrupt_enable && global_interrupt_enable) |=> branch_vector_ff == 13'h0000)
    else $error("vector shown without a pending interrupt");

  AST_NO_WAKE_AWAKE: assert property (
    !core_sleep |=> !wake_ff)
    else $error("wake raised while core awake");

  AST_WORD_NOT_LOST: assert property (
    word_in |=> receive_interrupt_flag_ff || overrun_error_flag_ff)
    else $error("completed word neither flagged nor reported as overrun");

  AST_OVR_HOLDS_OFF: assert property (
    overrun_error_flag_ff |-> !w.en && !word_in)
    else $error("receiver enabled during overrun");

  AST_NINTH_KEPT: assert property (
    (load && rx9) |=> received_ninth_bit_ff == $past(w.data[8]))
    else $error("ninth bit not kept in nine bit mode");

  AST_STATUS_VIEW: assert property (
    (setup && !pwrite && addr_ok && idx == IDX_RX_STAT) |=>
      prdata_ff == {24'h000000, $past(rx_ctl_ff), 1'b0, $past(overrun_error_flag_ff), $past(received_ninth_bit_ff)})
    else $error("status read does not show ninth bit and error flags");

  AST_BUF_VIEW: assert property (
    (setup && !pwrite && addr_ok && idx == IDX_RX_BUF) |=>
      prdata_ff == {24'h000000, $past(rx_buf_ff)})
    else $error("buffer read does not return the received byte");

  AST_BUF_READ_ONLY: assert property (
    (wr && addr_ok && idx == IDX_RX_BUF && !load) |=> $stable(rx_buf_ff))
    else $error("receive buffer changed by a write");

  AST_SLVERR: assert property (
    (setup && !addr_ok) |=> pslverr_ff && pready_ff && prdata_ff == 32'h0000_0000)
    else $error("bad address not refused");

  AST_IDLE_ANSWER: assert property (
    !setup |=> !pready_ff && !pslverr_ff && prdata_ff == 32'h0000_0000)
    else $error("apb answer outside the access cycle");

  AST_EVT_SET_WINS: assert property (
    (load || ovr) |=> (evt_stat_ff & $past(evt_set)) == $past(evt_set))
    else $error("event status bit lost on set");

  AST_IRQ_SET: assert property (
    |(evt_stat_ff & evt_mask_ff) |=> irq_ff)
    else $error("event interrupt missing for unmasked status");

  AST_IRQ_CLEAR: assert property (
    !(|(evt_stat_ff & evt_mask_ff)) |=> !irq_ff)
    else $error("event interrupt without unmasked status");

  COV_WORD: cover property (load);
  COV_OVERRUN: cover property (ovr);
  COV_WAKE_SLEEP: cover property (core_sleep && load ##[1:4] wake_ff);
  COV_NINE: cover property (load && rx9 && w.data[8]);
  COV_OVR_CLEARED: cover property (overrun_error_flag_ff ##1 !overrun_error_flag_ff);
endmodule

/* sim/usr_master_model.sv */
// partner model: external synchronous master driving shift clock and data
`timescale 1ns/1ns
module usr_master_model (
  // link pins
  output logic sck_pin,
  output logic sdata_pin
);
  initial begin
    sck_pin = 1'b1; // clock idles high outside frames
    sdata_pin = 1'b0;
  end
  // shifts one word lsb first, data changes only while the clock is high
  task automatic send(input logic [8:0] word, input int nbits);
    #17;
    for (int i = 0; i < nbits; i++) begin
      sdata_pin = word[i];
      #200 sck_pin = 1'b0;
      #200 sck_pin = 1'b1;
    end
    // released data line must not show a stale bit
    sdata_pin = ~word[nbits-1];
  endtask
endmodule

/* sim/usr_rx_tb.sv */
// testbench of the synchronous slave receiver
`timescale 1ns/1ns
module usr_rx_tb
  import usr_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sck_pin, sdata_pin, wake, core_irq, irq;
  logic core_sleep = 1'b0;
  logic [12:0] branch_vector;
  logic [31:0] d;
  logic e;
  int err_total = 0;
  int n_checks = 0;
  logic [7:0] zi [6] = '{IDX_INT_CTRL, IDX_PFLAGS, IDX_RX_STAT, IDX_RX_BUF, IDX_PENABLES, IDX_BAUD};

  always #25 clk_sys = ~clk_sys;

  usr_rx #(.ADDR_W(12)) u_dut (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck_pin(sck_pin), .sdata_pin(sdata_pin),
    .core_sleep(core_sleep), .wake(wake), .core_irq(core_irq),
    .branch_vector(branch_vector), .irq(irq));
  usr_master_model u_master (.sck_pin(sck_pin), .sdata_pin(sdata_pin));

  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer, result taken at the edge where pready is high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] r;
    logic x;
    apb(1'b1, idx, wd, r, x);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    logic x;
    apb(1'b0, idx, 8'h00, r, x);
    chk(r, {24'h0, exp});
  endtask

  // polls a register bit under a bounded count
  task automatic wait_bit(input logic [7:0] idx, input int unsigned b);
    logic [31:0] r;
    logic x;
    int n;
    n = 0;
    do begin
      apb(1'b0, idx, 8'h00, r, x);
      n++;
    end while (r[b] !== 1'b1 && n < 40);
    if (n >= 40) begin
      err_total++;
      end_sim();
    end
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys);
    err_total++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (zi[i]) rd_chk(zi[i], RST_ZERO);
    rd_chk(IDX_TX_STAT, RST_TX_STAT);
    apb(1'b0, 8'h20, 8'h00, d, e);
    chk({31'h0, e}, 32'h1);
    chk(d, 32'h0);
    wr(IDX_RX_BUF, 8'hff);
    rd_chk(IDX_RX_BUF, 8'h00);
    $display("test reset and map done");
    wr(IDX_TX_STAT, 8'h10);
    rd_chk(IDX_TX_STAT, 8'h12);
    wr(IDX_RX_STAT, 8'ha0);
    u_master.send(9'h01e, 8);
    repeat (8) @(posedge clk_sys);
    rd_chk(IDX_PFLAGS, 8'h00);
    $display("test no continuous enable done");
    wr(IDX_PENABLES, 8'h20);
    wr(IDX_INT_CTRL, 8'hc0);
    wr(IDX_EVT_MASK, 8'h01);
    wr(IDX_RX_STAT, 8'hb0);
    @(posedge clk_sys);
    core_sleep <= 1'b1;
    u_master.send(9'h01e, 8);
    wait_bit(IDX_PFLAGS, B_RECEIVE_INTERRUPT_FLAG);
    @(negedge clk_sys);
    chk({31'h0, wake}, 32'h1);
    chk({31'h0, core_irq}, 32'h1);
    chk({19'h0, branch_vector}, {19'h0, VECTOR_ADDR});
    chk({31'h0, irq}, 32'h1);
    rd_chk(IDX_RX_STAT, 8'hb0);
    rd_chk(IDX_RX_BUF, 8'h1e);
    rd_chk(IDX_PFLAGS, 8'h00);
    core_sleep <= 1'b0;
    $display("test sleep reception done");
    wr(IDX_RX_STAT, 8'hd0);
    u_master.send(9'h1c6, 9);
    wait_bit(IDX_PFLAGS, B_RECEIVE_INTERRUPT_FLAG);
    rd_chk(IDX_RX_STAT, 8'hd1);
    rd_chk(IDX_RX_BUF, 8'hc6);
    $display("test nine bit done");
    wr(IDX_RX_STAT, 8'h90);
    wr(IDX_PENABLES, 8'h00);
    u_master.send(9'h033, 8);
    wait_bit(IDX_PFLAGS, B_RECEIVE_INTERRUPT_FLAG);
    @(negedge clk_sys);
    chk({31'h0, core_irq}, 32'h0);
    u_master.send(9'h0f1, 8);
    wait_bit(IDX_RX_STAT, B_OVERRUN_ERROR_FLAG);
    rd_chk(IDX_RX_STAT, 8'h92);
    rd_chk(IDX_EVT_STAT, 8'h03);
    rd_chk(IDX_RX_BUF, 8'h33);
    u_master.send(9'h055, 8);
    repeat (8) @(posedge clk_sys);
    rd_chk(IDX_PFLAGS, 8'h00);
    wr(IDX_RX_STAT, 8'h80);
    wr(IDX_RX_STAT, 8'h90);
    rd_chk(IDX_RX_STAT, 8'h90);
    $display("test overrun done");
    wr(IDX_EVT_MASK, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_EVT_STAT, 8'h03);
    rd_chk(IDX_EVT_STAT, 8'h00);
    $display("test event mask done");
    end_sim();
  end
endmodule
